// ==== reset_strap_latch.sv ====
// hardware reset qualification, strap capture and shared power-down/irq pins
// Functional notes
// - reset pin low 1 us starts full reset
// - reset returns all register bits to defaults; here only mode, power-down and oe clear
// - reset re-captures every strap, replacing old values
// - straps sampled during reset select configuration
// - shared pin defaults to power-down input role
// - power-down role: pin low enters power-down
// - interrupt role: open-drain low on enabled event
// - four strap bits land in address bits 4:1
// - address bit 0 fixed per port
// - first port answers even addresses 0 to 30
// - second port answers odd addresses 1 to 31
// - absent strap resistor samples as zero
`timescale 1ns/1ps
`include "rsl_consts.svh"

module reset_strap_latch
  import rsl_pkg::*;
#(
  parameter int RST_MIN_CYC = `RSL_RST_MIN_CYC
) (
  input  wire logic                    clock,
  input  wire logic                    rst_b,
  input  wire logic                    resetPin_b,
  input  wire logic                    addr_strap_bit1,
  input  wire logic                    addr_strap_bit2,
  input  wire logic                    addr_strap_bit3,
  input  wire logic                    addr_strap_bit4,
  input  wire logic                    pdnIrqPinFirstIn,
  input  wire logic                    pdnIrqPinSecondIn,
  input  wire logic                    irqModeFirst,
  input  wire logic                    irqModeSecond,
  input  wire logic                    irqEventFirst,
  input  wire logic                    irqEventSecond,
  output logic                         resetActive,
  output logic [`RSL_ADDR_W-1:0]       physAddrFirst,
  output logic [`RSL_ADDR_W-1:0]       physAddrSecond,
  output logic                         powerDownFirst,
  output logic                         powerDownSecond,
  output logic                         pdnIrqPinFirstOut,
  output logic                         pdnIrqPinFirstOe,
  output logic                         pdnIrqPinSecondOut,
  output logic                         pdnIrqPinSecondOe
);

  // the run-to-arm edge is the first low sample, so arm needs one fewer
  localparam logic [`RSL_CNT_W-1:0] MIN_LAST = `RSL_CNT_W'(RST_MIN_CYC - 2);

  // pin synchronisers; first stage read only by second stage
  logic                    rstMeta_reg;
  logic                    rstSync_reg;
  logic [`RSL_STRAP_W-1:0] strapMeta_reg;
  logic [`RSL_STRAP_W-1:0] strapSync_reg;
  logic [1:0]              pdnMeta_reg;
  logic [1:0]              pdnSync_reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_reg   <= 1'b0;
      rstSync_reg   <= 1'b0;
      strapMeta_reg <= `RSL_STRAP_RST;
      strapSync_reg <= `RSL_STRAP_RST;
      pdnMeta_reg   <= 2'h3;
      pdnSync_reg   <= 2'h3;
    end else begin
      rstMeta_reg   <= resetPin_b;
      rstSync_reg   <= rstMeta_reg;
      strapMeta_reg <= {addr_strap_bit4, addr_strap_bit3, addr_strap_bit2, addr_strap_bit1};
      strapSync_reg <= strapMeta_reg;
      pdnMeta_reg   <= {pdnIrqPinSecondIn, pdnIrqPinFirstIn};
      pdnSync_reg   <= pdnMeta_reg;
    end
  end

  // reset qualification; short glitches below the minimum are ignored
  rsl_state_e              state_reg;
  rsl_state_e              state_next;
  logic [`RSL_CNT_W-1:0]   lowCnt_reg;
  logic [`RSL_CNT_W-1:0]   lowCnt_next;
  logic [`RSL_STRAP_W-1:0] strapLatch_reg;
  logic [`RSL_STRAP_W-1:0] strapLatch_next;

  wire pinLow    = !rstSync_reg;
  wire qualified = (state_reg == ST_ARM) && pinLow && (lowCnt_reg == MIN_LAST);
  wire releasing = (state_reg == ST_SAMPLE) && !pinLow;

  always_comb begin
    state_next  = state_reg;
    lowCnt_next = '0;
    unique case (state_reg)
      ST_RUN: begin
        if (pinLow) begin
          state_next = ST_ARM;
        end
      end
      ST_ARM: begin
        lowCnt_next = lowCnt_reg + `RSL_CNT_W'(1);
        if (!pinLow) begin
          state_next = ST_RUN;
        end else if (qualified) begin
          state_next = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (releasing) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_SAMPLE;
      end
    endcase
  end

  // capture on release so the last level seen in reset wins
  assign strapLatch_next = releasing ? strapSync_reg : strapLatch_reg;

  // power-on reset also starts in sampling so straps load at power-up
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg      <= ST_SAMPLE;
      lowCnt_reg     <= '0;
      strapLatch_reg <= `RSL_STRAP_RST;
    end else begin
      state_reg      <= state_next;
      lowCnt_reg     <= lowCnt_next;
      strapLatch_reg <= strapLatch_next;
    end
  end

  wire                   inReset   = (state_next == ST_SAMPLE);
  wire [`RSL_ADDR_W-1:0] addrFirst = {strapLatch_next, `RSL_PORT_FIRST_LSB};
  wire [`RSL_ADDR_W-1:0] addrSecond = {strapLatch_next, `RSL_PORT_SECOND_LSB};

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      resetActive    <= 1'b1;
      physAddrFirst  <= {`RSL_STRAP_RST, `RSL_PORT_FIRST_LSB};
      physAddrSecond <= {`RSL_STRAP_RST, `RSL_PORT_SECOND_LSB};
    end else begin
      resetActive    <= inReset;
      physAddrFirst  <= addrFirst;
      physAddrSecond <= addrSecond;
    end
  end

  // per-port shared pin: power-down input by default, irq when enabled
  wire [1:0] irqModeReq = {irqModeSecond, irqModeFirst};
  wire [1:0] irqEvent   = {irqEventSecond, irqEventFirst};
  logic [1:0] irqMode_reg;
  logic [1:0] pdn_reg;
  logic [1:0] oe_reg;

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      // mode is cleared for the whole reset and only taken once it is over
      wire modeNext = inReset ? 1'b0 : irqModeReq[p];
      wire pdnNext  = !inReset && !modeNext && !pdnSync_reg[p];
      wire oeNext   = !inReset && modeNext && irqEvent[p];

      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          irqMode_reg[p] <= 1'b0;
          pdn_reg[p]     <= 1'b0;
          oe_reg[p]      <= 1'b0;
        end else begin
          irqMode_reg[p] <= modeNext;
          pdn_reg[p]     <= pdnNext;
          oe_reg[p]      <= oeNext;
        end
      end

      property p_pdn_low;
        @(posedge clock) disable iff (!rst_b)
          (state_next != ST_SAMPLE && !irqModeReq[p] && !pdnSync_reg[p]) |=> pdn_reg[p];
      endproperty
      a_pdn_low: assert property (p_pdn_low) else $error("power-down missed");

      property p_irq_drive;
        @(posedge clock) disable iff (!rst_b)
          (state_next != ST_SAMPLE && irqModeReq[p] && irqEvent[p]) |=> oe_reg[p] && !pdn_reg[p];
      endproperty
      a_irq_drive: assert property (p_irq_drive) else $error("irq pin not pulled");

      property p_irq_off_reset;
        @(posedge clock) disable iff (!rst_b)
          (state_reg == ST_SAMPLE) |-> !oe_reg[p] && !irqMode_reg[p];
      endproperty
      a_irq_off_reset: assert property (p_irq_off_reset) else $error("irq role in reset");

      property p_default_pdn;
        @(posedge clock) disable iff (!rst_b)
          (!irqModeReq[p]) |=> !oe_reg[p];
      endproperty
      a_default_pdn: assert property (p_default_pdn) else $error("irq without mode");
    end
  endgenerate

  // open drain: only ever drives low, enable carries the level
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pdnIrqPinFirstOut  <= 1'b0;
      pdnIrqPinSecondOut <= 1'b0;
    end else begin
      pdnIrqPinFirstOut  <= 1'b0;
      pdnIrqPinSecondOut <= 1'b0;
    end
  end

  assign powerDownFirst   = pdn_reg[0];
  assign powerDownSecond  = pdn_reg[1];
  assign pdnIrqPinFirstOe  = oe_reg[0];
  assign pdnIrqPinSecondOe = oe_reg[1];

  // helper for the hold time check
  logic [`RSL_CNT_W-1:0] lowRun_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lowRun_reg <= '0;
    end else if (!pinLow) begin
      lowRun_reg <= '0;
    end else if (lowRun_reg != {`RSL_CNT_W{1'b1}}) begin
      lowRun_reg <= lowRun_reg + `RSL_CNT_W'(1);
    end
  end

  property p_min_hold;
    @(posedge clock) disable iff (!rst_b)
      (state_reg == ST_ARM ##1 state_reg == ST_SAMPLE) |-> lowRun_reg >= `RSL_CNT_W'(RST_MIN_CYC);
  endproperty
  a_min_hold: assert property (p_min_hold) else $error("reset taken too early");

  property p_long_low;
    @(posedge clock) disable iff (!rst_b)
      (state_reg == ST_ARM && pinLow && lowCnt_reg == MIN_LAST) |=> resetActive;
  endproperty
  a_long_low: assert property (p_long_low) else $error("qualified reset lost");

  property p_capture;
    @(posedge clock) disable iff (!rst_b)
      (state_reg == ST_SAMPLE && !pinLow) |=> strapLatch_reg == $past(strapSync_reg)
        && physAddrFirst[4:1] == $past(strapSync_reg) && !resetActive;
  endproperty
  a_capture: assert property (p_capture) else $error("strap not captured");

  property p_hold;
    @(posedge clock) disable iff (!rst_b)
      ($past(state_reg) != ST_SAMPLE) |-> $stable(strapLatch_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("strap changed outside reset");

  property p_addr_pair;
    @(posedge clock) disable iff (!rst_b)
      !physAddrFirst[0] && physAddrSecond[0]
        && physAddrFirst[4:1] == physAddrSecond[4:1];
  endproperty
  a_addr_pair: assert property (p_addr_pair) else $error("port address parity wrong");

endmodule : reset_strap_latch

// ==== reset_strap_latch_test.sv ====
// self-checking bench for reset qualification, strap capture and shared pins
`timescale 1ns/1ps
module reset_strap_latch_test;
  localparam int MIN_CYC = 4;
  logic       clock, rst_b, pulseGo, lowF, lowS, modeF, modeS, evF, evS;
  logic       resetPin_b, resetActive, pdF, pdS, outF, oeF, outS, oeS, prevActive;
  logic [7:0] pulseLen;
  logic [3:0] strapVal, strapFit, strapPins, v;
  logic [4:0] addrF, addrS;
  logic [9:0] expQ[$];
  logic [9:0] expV, irqExp;
  int         errorCnt, samplesChecked;
  // pulled-up shared pins: low if the block or the board pulls them
  wire        pinF = ~(oeF | lowF);
  wire        pinS = ~(oeS | lowS);

  rsl_board rsl_board_i (.clock(clock), .pulseGo(pulseGo), .pulseLen(pulseLen),
    .strapVal(strapVal), .strapFit(strapFit), .resetPin_b(resetPin_b), .strapPins(strapPins));

  reset_strap_latch #(.RST_MIN_CYC(MIN_CYC)) reset_strap_latch_i (.clock(clock), .rst_b(rst_b),
    .resetPin_b(resetPin_b), .addr_strap_bit1(strapPins[0]), .addr_strap_bit2(strapPins[1]),
    .addr_strap_bit3(strapPins[2]), .addr_strap_bit4(strapPins[3]), .pdnIrqPinFirstIn(pinF),
    .pdnIrqPinSecondIn(pinS), .irqModeFirst(modeF), .irqModeSecond(modeS),
    .irqEventFirst(evF), .irqEventSecond(evS), .resetActive(resetActive),
    .physAddrFirst(addrF), .physAddrSecond(addrS), .powerDownFirst(pdF),
    .powerDownSecond(pdS), .pdnIrqPinFirstOut(outF), .pdnIrqPinFirstOe(oeF),
    .pdnIrqPinSecondOut(outS), .pdnIrqPinSecondOe(oeS));

  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic completeRun;
    $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : completeRun

  // straps flip on the edge the pulse starts, so a capture before reset would miss the noted value
  task automatic do_reset(input logic [7:0] len, input logic [3:0] sv, input logic [3:0] f);
    strapVal <= ~sv;
    strapFit <= f;
    pulseLen <= len;
    pulseGo  <= 1'b1;
    if (len >= 8'(MIN_CYC)) expQ.push_back({sv & f, 1'b0, sv & f, 1'b1});
    @(posedge clock);
    pulseGo  <= 1'b0;
    strapVal <= sv;
    // last edge before release: pin time plus two sync stages
    repeat (len + 8'h02) @(posedge clock);
    #1;
    if (len >= 8'(MIN_CYC)) begin
      check("reset outs", {5'h00, resetActive, pdF, pdS, oeF, oeS}, 10'h010);
    end else begin
      check("reset refused", {9'h000, resetActive}, 10'h000);
    end
    repeat (12) @(posedge clock);
  endtask : do_reset

  // any capture without a note pops nothing and fails
  always @(posedge clock) begin
    prevActive <= resetActive;
    if (rst_b && prevActive === 1'b1 && resetActive === 1'b0) begin
      expV = (expQ.size() > 0) ? expQ.pop_front() : 10'h3FF;
      check("addresses", {addrF, addrS}, expV);
    end
  end

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial begin
    #20000;
    errorCnt++;
    completeRun();
  end

  initial begin
    {rst_b, pulseGo, lowF, lowS, modeF, modeS, evF, evS} = 8'h00;
    {pulseLen, strapVal, strapFit} = 16'h0000;
    void'($urandom(57));
    repeat (16) @(posedge clock);
    check("addr in reset", {addrF, addrS}, 10'h001);
    check("outs in reset", {5'h00, resetActive, pdF, pdS, oeF, oeS}, 10'h010);
    expQ.push_back(10'h001);
    rst_b <= 1'b1;
    repeat (12) @(posedge clock);
    $display("test power-on done");
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 4'hF : 4'($urandom);
      do_reset(8'(MIN_CYC + 8), v, 4'hF);
    end
    do_reset(8'(MIN_CYC), 4'h6, 4'hF);
    do_reset(8'(MIN_CYC + 8), 4'hF, 4'h5);
    do_reset(8'(MIN_CYC - 1), 4'hA, 4'hF);
    check("held addr", {addrF, addrS}, 10'h14B);
    $display("test strap capture done");
    for (int i = 0; i < 2; i++) begin
      lowF <= (i == 0);
      lowS <= (i == 1);
      repeat (5) @(posedge clock);
      #1;
      check("power down", {8'h00, pdF, pdS}, (i == 0) ? 10'h002 : 10'h001);
      @(posedge clock);
    end
    lowS <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      modeF <= k[0];
      evF   <= k[1];
      modeS <= k[1];
      evS   <= 1'b1;
      repeat (8) @(posedge clock);
      #1;
      irqExp = {4'h0, k[0] & k[1], 1'b0, k[1], 3'h0};
      check("irq pins", {4'h0, oeF, outF, oeS, outS, pdF, pdS}, irqExp);
      @(posedge clock);
    end
    // irq role and events still requested: reset must silence both pins
    do_reset(8'(MIN_CYC + 8), 4'h3, 4'hF);
    $display("test shared pins done");
    check("notes left", 10'(expQ.size()), 10'h000);
    completeRun();
  end
endmodule : reset_strap_latch_test

// ==== rsl_board.sv ====
// board model: reset controller pulse and strap resistors with weak pull-downs
`timescale 1ns/1ps
module rsl_board (
  input  wire logic       clock,
  input  wire logic       pulseGo,
  input  wire logic [7:0] pulseLen,
  input  wire logic [3:0] strapVal,
  input  wire logic [3:0] strapFit,
  output logic            resetPin_b,
  output logic [3:0]      strapPins
);
  logic [7:0] pulseCnt_reg = 8'h00;
  // no retrigger while a pulse runs, as a real controller would
  always @(posedge clock) begin
    if (pulseCnt_reg != 8'h00) pulseCnt_reg <= pulseCnt_reg - 8'h01;
    else if (pulseGo) pulseCnt_reg <= pulseLen;
  end
  assign resetPin_b = (pulseCnt_reg == 8'h00);
  assign strapPins  = strapVal & strapFit;
endmodule : rsl_board

// ==== rsl_consts.svh ====
// timing counts and field positions for the reset and strap capture block
`ifndef RSL_CONSTS_SVH
`define RSL_CONSTS_SVH
`define RSL_CLK_PERIOD_PS 8000
`define RSL_RST_MIN_NS 1000
`define RSL_RST_MIN_CYC ((`RSL_RST_MIN_NS * 1000 + `RSL_CLK_PERIOD_PS - 1) / `RSL_CLK_PERIOD_PS)
`define RSL_CNT_W 8
`define RSL_STRAP_W 4
`define RSL_ADDR_W 5
`define RSL_STRAP_RST 4'h0
`define RSL_PORT_FIRST_LSB 1'b0
`define RSL_PORT_SECOND_LSB 1'b1
`endif

// ==== rsl_pkg.sv ====
// types for the reset and strap capture block
package rsl_pkg;
  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_ARM    = 2'b01,
    ST_SAMPLE = 2'b10
  } rsl_state_e;
endpackage : rsl_pkg
